/* hw/spf_pkg.sv */
package spf_pkg;

  // Bus clock is half the clock-source output
  localparam int unsigned CLK_DIV          = 2;
  // Debug bit time in debug-clock cycles
  localparam int unsigned BIT_CYCLES       = 16;
  localparam int unsigned BIT_CNT_W        = 4;
  // Speedup pulse length in bus cycles
  localparam logic [3:0]  SPEEDUP_CYCLES   = 4'h1;
  localparam logic [3:0]  BIT_CNT_LAST     = 4'hF;

  // Option bit reset values
  localparam logic        RST_PIN_EN_RST   = 1'b0;
  localparam logic        DBG_PIN_EN_RST   = 1'b1;

  // Pin indexes for the general I/O pins
  localparam int unsigned NUM_IO           = 4;
  localparam int unsigned IO_BIT0          = 0;
  localparam int unsigned IO_BIT1          = 1;
  localparam int unsigned IO_BIT4          = 2;
  localparam int unsigned IO_BIT5          = 3;

  typedef enum logic [4:0] {
    FN_GPIO      = 5'h01,
    FN_KEYPAD    = 5'h02,
    FN_TIMER_CLK = 5'h04,
    FN_RESET     = 5'h08,
    FN_ANALOG    = 5'h10
  } spf_fn_t;

  // Per-pin pad control
  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_down;
  } spf_pad_t;

  // Software option bits
  typedef struct packed {
    logic reset_pin_enable;
    logic debug_pin_enable;
  } spf_opt_t;

endpackage : spf_pkg

/* hw/spf_bit_timer.sv */
`timescale 1ns/1ns
// Counts one debug bit time at bus-clock rate
module spf_bit_timer (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      speedup,
  output logic      bit_done
);

  logic [spf_pkg::BIT_CNT_W-1:0] cnt_q;
  logic                          busy_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q  <= '0;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == spf_pkg::BIT_CNT_LAST) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign busy     = busy_q;
  assign bit_done = busy_q && (cnt_q == spf_pkg::BIT_CNT_LAST);
  assign speedup  = busy_q && (cnt_q < spf_pkg::SPEEDUP_CYCLES);

endmodule : spf_bit_timer

/* hw/spf_priority.sv */
`timescale 1ns/1ns
// Picks the highest active function, lowest bit ranks lowest
module spf_priority (
  input  wire logic [4:0]      req,
  output spf_pkg::spf_fn_t     grant
);

  always_comb begin
    grant = spf_pkg::FN_GPIO;
    for (int i = 0; i < 5; i++) begin
      if (req[i]) begin
        grant = spf_pkg::spf_fn_t'(5'h01 << i);
      end
    end
  end

endmodule : spf_priority

/* hw/spf_pin_ctrl.sv */
`timescale 1ns/1ns
// What this block does
// [R1] After power-on, shared pin is plain input
// [R2] Reset-enable bit turns pin into reset input
// [R3] Reset function sticks until power-on reset
// [R4] Pin low in reset function resets device
// [R5] Reset function turns on pullup automatically
// [R6] During reset, debug pin samples mode strap
// [R7] After reset, debug pin carries debug link
// [R8] Debug or strap function keeps pullup on
// [R9] Software clears debug-enable for general output
// [R10] Strap high at reset release gives run
// [R11] Strap held low gives background mode
// [R12] Each debug bit lasts 16 debug clocks
// [R13] Debug clock equals bus clock rate
// [R14] Bus clock is clock-source output halved
// [R15] Debug line open-drain with speedup pulses
// [R16] Other pins reset to high-Z, no pulls
// [R17] Highest-priority active function owns the pin
// [R18] General debug-pin function is output only
// [R19] Keypad inputs only wake from stop/wait
// [R20] Software pulls come from port control
// [R21] Programming voltage disables reset-pin pulls
// [R22] Function changes take effect next cycle
module spf_pin_ctrl (
  // Clock and reset
  input  wire logic                            CLK_SYS,
  input  wire logic                            SYS_RST,
  input  wire logic                            POR,
  // Option bits and their write strobe
  input  wire logic                            OPT_WR,
  input  wire spf_pkg::spf_opt_t               OPT_WDATA,
  // Shared reset-capable pin
  input  wire logic                            PORT_A_BIT2_INPUT,
  input  wire logic                            PROG_VOLTAGE_PRESENT,
  input  wire logic                            KEYPAD_WAKE_EN_2,
  input  wire logic                            TIMER_EXTERNAL_CLOCK_EN,
  // Debug/output pin
  input  wire logic                            DEBUG_LINE_IN,
  input  wire logic                            PORT_A_BIT3_OUTPUT,
  input  wire logic                            COMPARATOR_OUTPUT_EN,
  input  wire logic                            COMPARATOR_OUTPUT,
  input  wire logic                            DBG_TX_START,
  input  wire logic                            DBG_TX_BIT,
  // General I/O pins
  input  wire logic [spf_pkg::NUM_IO-1:0]      IO_IN,
  input  wire logic [spf_pkg::NUM_IO-1:0]      IO_OUT,
  input  wire logic [spf_pkg::NUM_IO-1:0]      IO_DIR_OUT,
  input  wire logic [spf_pkg::NUM_IO-1:0]      SOFTWARE_PULL_CONTROL_EN,
  input  wire logic [spf_pkg::NUM_IO-1:0]      SOFTWARE_PULL_CONTROL_UP,
  input  wire logic [spf_pkg::NUM_IO-1:0]      KEYPAD_WAKE_EN,
  input  wire logic [1:0]                      COMPARATOR_INPUT_EN,
  input  wire logic                            LOW_POWER_STATE,
  // Clock-source output
  input  wire logic                            INTERNAL_CLOCK_SOURCE,
  // Outputs
  output logic                                 BUS_CLK,
  output logic                                 EXT_RESET_REQ,
  output logic                                 BACKGROUND_MODE,
  output logic                                 RESET_PIN_ACTIVE,
  output logic                                 DEBUG_PIN_ACTIVE,
  output logic                                 PORT_A_BIT2_DATA,
  output logic                                 TIMER_CLK_IN,
  output logic                                 DBG_RX_BIT,
  output logic                                 DBG_BIT_DONE,
  output logic                                 KEYPAD_WAKE,
  output spf_pkg::spf_pad_t                    PAD_BIT2,
  output spf_pkg::spf_pad_t                    PAD_BIT3,
  output spf_pkg::spf_pad_t [spf_pkg::NUM_IO-1:0] PAD_IO,
  output logic [spf_pkg::NUM_IO-1:0]           IO_DATA
);

  logic              rst_pin_en_q;
  logic              dbg_pin_en_q;
  logic              in_reset_q;
  logic              bg_mode_q;
  logic              strap_q;
  logic              bus_clk_q;
  logic              ext_rst_q;
  logic              bit2_data_q;
  logic              timer_external_clock_q;
  logic              bit2_data_d;
  logic              timer_external_clock_d;
  logic              rx_q;
  logic              done_q;
  logic              wake_q;
  spf_pkg::spf_pad_t pad2_q;
  spf_pkg::spf_pad_t pad2_d;
  spf_pkg::spf_pad_t pad3_q;
  spf_pkg::spf_pad_t pad3_d;
  logic              tmr_busy;
  logic              tmr_speedup;
  logic              tmr_done;
  spf_pkg::spf_fn_t  bit2_fn;
  spf_pkg::spf_fn_t  io_fn [spf_pkg::NUM_IO];

  // Bus clock from the clock-source output; bus-rate toggle register
  // Reset is held for many source edges, so sampling it here cannot miss it;
  // without it the divider would never leave an unknown state
  always_ff @(posedge INTERNAL_CLOCK_SOURCE) begin
    if (SYS_RST) begin
      bus_clk_q <= 1'b0;
    end else begin
      bus_clk_q <= ~bus_clk_q; // [R14]
    end
  end

  // Option bits; reset-pin enable is write-once-to-one until power-on
  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      rst_pin_en_q <= spf_pkg::RST_PIN_EN_RST; // [R1]
    end else if (OPT_WR && OPT_WDATA.reset_pin_enable) begin
      rst_pin_en_q <= 1'b1; // [R2] [R3]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dbg_pin_en_q <= spf_pkg::DBG_PIN_EN_RST;
    end else if (OPT_WR) begin
      dbg_pin_en_q <= OPT_WDATA.debug_pin_enable; // [R9]
    end
  end

  // Strap is sampled while in reset and latched at release
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      in_reset_q <= 1'b1;
      strap_q    <= DEBUG_LINE_IN; // [R6]
    end else begin
      in_reset_q <= 1'b0;
      strap_q    <= strap_q;
    end
  end

  // Only a low strap at any reset release forces background mode; power-on clears it
  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      bg_mode_q <= 1'b0;
    end else if (in_reset_q && !SYS_RST) begin
      bg_mode_q <= !strap_q; // [R10] [R11]
    end
  end

  // Reset request from the shared pin, a plain level
  always_ff @(posedge CLK_SYS) begin
    if (POR) begin
      ext_rst_q <= 1'b0;
    end else begin
      ext_rst_q <= rst_pin_en_q && !PORT_A_BIT2_INPUT; // [R4]
    end
  end

  // Function arbitration on the shared input pin
  spf_priority u_prio2 (
    .req   ({PROG_VOLTAGE_PRESENT, rst_pin_en_q, TIMER_EXTERNAL_CLOCK_EN,
             KEYPAD_WAKE_EN_2, 1'b1}),
    .grant (bit2_fn)
  ); // [R17] [R22]

  always_comb begin
    pad2_d           = '0;
    pad2_d.oe_n      = 1'b1;
    pad2_d.pull_up   = rst_pin_en_q && !PROG_VOLTAGE_PRESENT; // [R5] [R21]
    pad2_d.pull_down = 1'b0;
  end

  // Debug-bit timing at bus rate
  spf_bit_timer u_bit (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .start    (DBG_TX_START && dbg_pin_en_q && !in_reset_q),
    .busy     (tmr_busy),
    .speedup  (tmr_speedup),
    .bit_done (tmr_done)
  ); // [R12] [R13]

  // Debug/output pin drive; open-drain low or brief high speedup
  always_comb begin
    pad3_d         = '0;
    pad3_d.oe_n    = 1'b1;
    pad3_d.pull_up = 1'b0;
    if (SYS_RST || in_reset_q || dbg_pin_en_q) begin
      pad3_d.pull_up = 1'b1; // [R8]
      if (!SYS_RST && tmr_busy) begin
        if (!DBG_TX_BIT) begin
          pad3_d.out  = 1'b0;
          pad3_d.oe_n = 1'b0; // [R15]
        end else if (tmr_speedup) begin
          pad3_d.out  = 1'b1;
          pad3_d.oe_n = 1'b0; // [R15]
        end
      end
    end else if (COMPARATOR_OUTPUT_EN) begin
      pad3_d.out  = COMPARATOR_OUTPUT;
      pad3_d.oe_n = 1'b0; // [R17]
    end else begin
      pad3_d.out  = PORT_A_BIT3_OUTPUT;
      pad3_d.oe_n = 1'b0; // [R18]
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      // Reset pin keeps its pullup through reset so no false request follows
      pad2_q <= pad2_d; // [R5]
      pad3_q <= '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b1, pull_down: 1'b0}; // [R6]
    end else begin
      pad2_q <= pad2_d;
      pad3_q <= pad3_d;
    end
  end

  // Debug receive: sampled only while the debug function owns the pin
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rx_q   <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= tmr_done;
      if (dbg_pin_en_q) begin
        rx_q <= DEBUG_LINE_IN; // [R7]
      end
    end
  end

  // Shared input pin data routing per granted function
  always_comb begin
    bit2_data_d = 1'b0;
    timer_external_clock_d      = 1'b0;
    case (bit2_fn)
      spf_pkg::FN_GPIO,
      spf_pkg::FN_KEYPAD: begin
        bit2_data_d = PORT_A_BIT2_INPUT;
      end
      spf_pkg::FN_TIMER_CLK: begin
        bit2_data_d = PORT_A_BIT2_INPUT;
        timer_external_clock_d      = PORT_A_BIT2_INPUT; // [R17]
      end
      default: begin
        // Reset and programming functions hide the pin from the port
        bit2_data_d = 1'b0;
        timer_external_clock_d      = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      bit2_data_q <= 1'b0;
      timer_external_clock_q      <= 1'b0;
    end else begin
      bit2_data_q <= bit2_data_d;
      timer_external_clock_q      <= timer_external_clock_d;
    end
  end

  // General I/O pins: arbitration, pulls and keypad wake
  logic [spf_pkg::NUM_IO-1:0] wake_hit;
  logic [spf_pkg::NUM_IO-1:0] data_q;
  spf_pkg::spf_pad_t [spf_pkg::NUM_IO-1:0] padio_q;

  for (genvar g = 0; g < spf_pkg::NUM_IO; g++) begin : g_io
    localparam bit HAS_ANALOG = (g < 2);
    spf_priority u_prio (
      .req   ({1'b0, 1'b0, HAS_ANALOG ? COMPARATOR_INPUT_EN[g % 2] : 1'b0,
               KEYPAD_WAKE_EN[g], 1'b1}),
      .grant (io_fn[g])
    ); // [R17]
    assign wake_hit[g] = LOW_POWER_STATE && KEYPAD_WAKE_EN[g] && !IO_IN[g]
                         && io_fn[g] == spf_pkg::FN_KEYPAD; // [R19]
    always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
        padio_q[g] <= '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0}; // [R16]
        data_q[g]  <= 1'b0;
      end else begin
        padio_q[g].out       <= IO_OUT[g];
        padio_q[g].oe_n      <= !(IO_DIR_OUT[g] && io_fn[g] != spf_pkg::FN_TIMER_CLK);
        padio_q[g].pull_up   <= SOFTWARE_PULL_CONTROL_EN[g]
                                && SOFTWARE_PULL_CONTROL_UP[g]; // [R20]
        padio_q[g].pull_down <= SOFTWARE_PULL_CONTROL_EN[g]
                                && !SOFTWARE_PULL_CONTROL_UP[g]; // [R20]
        data_q[g]            <= IO_IN[g];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= |wake_hit ||
                (LOW_POWER_STATE && bit2_fn == spf_pkg::FN_KEYPAD && !PORT_A_BIT2_INPUT); // [R19]
    end
  end

  assign BUS_CLK          = bus_clk_q;
  assign EXT_RESET_REQ    = ext_rst_q;
  assign BACKGROUND_MODE  = bg_mode_q;
  assign RESET_PIN_ACTIVE = rst_pin_en_q;
  assign DEBUG_PIN_ACTIVE = dbg_pin_en_q;
  assign PORT_A_BIT2_DATA = bit2_data_q;
  assign TIMER_CLK_IN     = timer_external_clock_q;
  assign DBG_RX_BIT       = rx_q;
  assign DBG_BIT_DONE     = done_q;
  assign KEYPAD_WAKE      = wake_q;
  assign PAD_BIT2         = pad2_q;
  assign PAD_BIT3         = pad3_q;
  assign PAD_IO           = padio_q;
  assign IO_DATA          = data_q;

endmodule : spf_pin_ctrl

/* tb/spf_pin_checker.sv */
`timescale 1ns/1ns
module spf_pin_checker (
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              SYS_RST,
  input wire logic              POR,
  // Pin levels and requests
  input wire logic              PORT_A_BIT2_INPUT,
  input wire logic              PROG_VOLTAGE_PRESENT,
  input wire logic              DEBUG_LINE_IN,
  input wire logic              DBG_TX_START,
  input wire logic              LOW_POWER_STATE,
  // Design outputs
  input wire logic              EXT_RESET_REQ,
  input wire logic              BACKGROUND_MODE,
  input wire logic              RESET_PIN_ACTIVE,
  input wire logic              DEBUG_PIN_ACTIVE,
  input wire logic              DBG_BIT_DONE,
  input wire logic              KEYPAD_WAKE,
  input wire spf_pkg::spf_pad_t PAD_BIT2,
  input wire spf_pkg::spf_pad_t PAD_BIT3
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  ext_reset_a: assert property (RESET_PIN_ACTIVE && $past(RESET_PIN_ACTIVE) &&
    !PORT_A_BIT2_INPUT |=> EXT_RESET_REQ) else $error("No reset request");
  no_request_a: assert property (PORT_A_BIT2_INPUT |=> !EXT_RESET_REQ)
    else $error("Spurious reset request");
  reset_sticky_a: assert property (RESET_PIN_ACTIVE && !POR |=> RESET_PIN_ACTIVE)
    else $error("Reset function dropped");
  reset_pullup_a: assert property ((!PROG_VOLTAGE_PRESENT[*3] ##0 RESET_PIN_ACTIVE &&
    $past(RESET_PIN_ACTIVE)) |-> PAD_BIT2.pull_up) else $error("Reset pullup off");
  vpp_pulls_a: assert property (PROG_VOLTAGE_PRESENT[*2] |=>
    !PAD_BIT2.pull_up && !PAD_BIT2.pull_down) else $error("Pulls on under Vpp");
  bit2_input_a: assert property (PAD_BIT2.oe_n) else $error("Input pin driven");
  dbg_pullup_a: assert property (DEBUG_PIN_ACTIVE && $past(DEBUG_PIN_ACTIVE)
    |-> PAD_BIT3.pull_up) else $error("Debug pullup off");
  speedup_a: assert property (DEBUG_PIN_ACTIVE && !PAD_BIT3.oe_n && PAD_BIT3.out
    |=> PAD_BIT3.oe_n) else $error("High drive longer than a pulse");
  bit_length_a: assert property (DBG_BIT_DONE |-> $past(DBG_TX_START, 17))
    else $error("Bit time wrong");
  mode_pick_a: assert property ($fell(SYS_RST) |=>
    BACKGROUND_MODE == !$past(DEBUG_LINE_IN, 2)) else $error("Wrong start mode");
  wake_only_a: assert property (!LOW_POWER_STATE |=> !KEYPAD_WAKE)
    else $error("Wake outside low power");

  cover property (DBG_BIT_DONE);
  cover property (EXT_RESET_REQ);
  cover property (BACKGROUND_MODE);
endmodule : spf_pin_checker

bind spf_pin_ctrl spf_pin_checker i_chk (.*);

/* tb/spf_host_model.sv */
`timescale 1ns/1ns
module spf_host_model (
  // Clock
  input wire logic              clk,
  // Device pads
  input wire spf_pkg::spf_pad_t pad_dbg,
  input wire spf_pkg::spf_pad_t pad_rst,
  // Host controls
  input wire logic              hold_strap_low,
  input wire logic              pull_rst_low,
  // Resolved pin levels
  output logic                  dbg_line,
  output logic                  rst_line
);
  logic flip_q = 1'b0;

  // Undriven pins without pulls wander, so no stale level is seen
  always_ff @(posedge clk) flip_q <= ~flip_q;

  always_comb begin
    if (!pad_dbg.oe_n) dbg_line = pad_dbg.out;
    else if (hold_strap_low) dbg_line = 1'b0;
    else if (pad_dbg.pull_up) dbg_line = 1'b1;
    else dbg_line = flip_q;
  end

  always_comb begin
    if (pull_rst_low) rst_line = 1'b0;
    else if (pad_rst.pull_up) rst_line = 1'b1;
    else rst_line = flip_q;
  end
endmodule : spf_host_model

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  logic CLK_SYS = 1'b0, SYS_RST = 1'b1, POR = 1'b1, OPT_WR = 1'b0, INTERNAL_CLOCK_SOURCE = 1'b0;
  logic PROG_VOLTAGE_PRESENT = 1'b0, KEYPAD_WAKE_EN_2 = 1'b0, TIMER_EXTERNAL_CLOCK_EN = 1'b0;
  logic PORT_A_BIT3_OUTPUT = 1'b0, COMPARATOR_OUTPUT_EN = 1'b0, COMPARATOR_OUTPUT = 1'b0;
  logic DBG_TX_START = 1'b0, DBG_TX_BIT = 1'b0, LOW_POWER_STATE = 1'b0;
  logic [3:0] IO_IN = 4'hF, IO_OUT = 4'h0, IO_DIR_OUT = 4'h0, KEYPAD_WAKE_EN = 4'h0;
  logic [3:0] SOFTWARE_PULL_CONTROL_EN = 4'h0, SOFTWARE_PULL_CONTROL_UP = 4'h0, IO_DATA;
  logic [1:0] COMPARATOR_INPUT_EN = 2'h0;
  logic strap_low = 1'b0, rst_low = 1'b0, DEBUG_LINE_IN, PORT_A_BIT2_INPUT, BUS_CLK;
  logic EXT_RESET_REQ, BACKGROUND_MODE, RESET_PIN_ACTIVE, DEBUG_PIN_ACTIVE, PORT_A_BIT2_DATA;
  logic TIMER_CLK_IN, DBG_RX_BIT, DBG_BIT_DONE, KEYPAD_WAKE;
  spf_pkg::spf_opt_t OPT_WDATA = '0;
  spf_pkg::spf_pad_t PAD_BIT2, PAD_BIT3;
  spf_pkg::spf_pad_t [3:0] PAD_IO;
  int bad_count = 0;
  int checks_done = 0;

  always #4 CLK_SYS = ~CLK_SYS;
  always #3 INTERNAL_CLOCK_SOURCE = ~INTERNAL_CLOCK_SOURCE;

  spf_pin_ctrl i_dut (.*);
  spf_host_model i_host (.clk(CLK_SYS), .pad_dbg(PAD_BIT3), .pad_rst(PAD_BIT2),
    .hold_strap_low(strap_low), .pull_rst_low(rst_low), .dbg_line(DEBUG_LINE_IN),
    .rst_line(PORT_A_BIT2_INPUT));

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Strap is held past release so the sample cannot race the release edge
  task automatic do_reset(input logic por_on, input logic strap);
    strap_low = strap;
    SYS_RST = 1'b1;
    POR = por_on;
    cyc(10);
    SYS_RST = 1'b0;
    POR = 1'b0;
    cyc(3);
    strap_low = 1'b0;
  endtask : do_reset

  task automatic wr_opt(input logic rst_en, input logic dbg_en);
    OPT_WR = 1'b1;
    OPT_WDATA = '{rst_en, dbg_en};
    cyc(1);
    OPT_WR = 1'b0;
    cyc(2);
  endtask : wr_opt

  task automatic t_por();
    chk({RESET_PIN_ACTIVE, DEBUG_PIN_ACTIVE, BACKGROUND_MODE}, 8'h02);
    chk(PAD_BIT2[2:0], 8'h04);
    chk(PAD_BIT3.pull_up, 8'h01);
    for (int i = 0; i < 4; i++) chk(PAD_IO[i][2:0], 8'h04);
    $display("t_por done");
  endtask : t_por

  task automatic t_strap();
    do_reset(1'b1, 1'b1);
    chk(BACKGROUND_MODE, 8'h01);
    do_reset(1'b1, 1'b0);
    chk(BACKGROUND_MODE, 8'h00);
    $display("t_strap done");
  endtask : t_strap

  task automatic t_bit();
    int n;
    for (int b = 0; b < 2; b++) begin
      DBG_TX_BIT = b[0];
      DBG_TX_START = 1'b1;
      cyc(1);
      DBG_TX_START = 1'b0;
      n = 1;
      while (!DBG_BIT_DONE && n < 40) begin
        cyc(1);
        n++;
        if (n == 2) chk({PAD_BIT3.out, PAD_BIT3.oe_n}, {6'h00, b[0], 1'b0});
        if (n == 3) chk(PAD_BIT3.oe_n, b[0]);
        if (n == 5) chk(DEBUG_LINE_IN, b[0]);
      end
      // Sixteen busy cycles, then the registered done pulse
      chk(n, 8'd17);
      if (n == 40) tally_and_finish();
      cyc(1);
    end
    $display("t_bit done");
  endtask : t_bit

  task automatic t_gpout();
    wr_opt(1'b0, 1'b0);
    chk(DEBUG_PIN_ACTIVE, 8'h00);
    PORT_A_BIT3_OUTPUT = 1'b1;
    cyc(2);
    chk({PAD_BIT3.out, PAD_BIT3.oe_n}, 8'h02);
    COMPARATOR_OUTPUT_EN = 1'b1;
    cyc(2);
    chk({PAD_BIT3.out, PAD_BIT3.oe_n}, 8'h00);
    COMPARATOR_OUTPUT_EN = 1'b0;
    PORT_A_BIT3_OUTPUT = 1'b0;
    wr_opt(1'b0, 1'b1);
    $display("t_gpout done");
  endtask : t_gpout

  task automatic t_kbd();
    KEYPAD_WAKE_EN = 4'h1;
    IO_IN = 4'hE;
    SOFTWARE_PULL_CONTROL_EN = 4'hF;
    SOFTWARE_PULL_CONTROL_UP = 4'h5;
    cyc(2);
    chk(KEYPAD_WAKE, 8'h00);
    for (int i = 0; i < 4; i++) chk(PAD_IO[i][1:0], {~i[0], i[0]});
    LOW_POWER_STATE = 1'b1;
    cyc(2);
    chk(KEYPAD_WAKE, 8'h01);
    LOW_POWER_STATE = 1'b0;
    IO_IN = 4'hF;
    $display("t_kbd done");
  endtask : t_kbd

  task automatic t_rst_pin();
    wr_opt(1'b1, 1'b1);
    chk({RESET_PIN_ACTIVE, PAD_BIT2.pull_up}, 8'h03);
    wr_opt(1'b0, 1'b1);
    chk(RESET_PIN_ACTIVE, 8'h01);
    rst_low = 1'b1;
    cyc(2);
    chk(EXT_RESET_REQ, 8'h01);
    rst_low = 1'b0;
    PROG_VOLTAGE_PRESENT = 1'b1;
    cyc(3);
    chk(PAD_BIT2[1:0], 8'h00);
    PROG_VOLTAGE_PRESENT = 1'b0;
    do_reset(1'b0, 1'b0);
    chk(RESET_PIN_ACTIVE, 8'h01);
    do_reset(1'b1, 1'b0);
    chk(RESET_PIN_ACTIVE, 8'h00);
    $display("t_rst_pin done");
  endtask : t_rst_pin

  task automatic t_paths();
    logic p;
    TIMER_EXTERNAL_CLOCK_EN = 1'b1;
    cyc(2);
    for (int i = 0; i < 2; i++) begin
      p = PORT_A_BIT2_INPUT;
      cyc(1);
      chk({PORT_A_BIT2_DATA, TIMER_CLK_IN}, {6'h00, p, p});
    end
    TIMER_EXTERNAL_CLOCK_EN = 1'b0;
    KEYPAD_WAKE_EN_2 = 1'b1;
    LOW_POWER_STATE = 1'b1;
    rst_low = 1'b1;
    cyc(2);
    chk({KEYPAD_WAKE, TIMER_CLK_IN}, 8'h02);
    KEYPAD_WAKE_EN_2 = 1'b0;
    LOW_POWER_STATE = 1'b0;
    rst_low = 1'b0;
    IO_IN = 4'hA;
    IO_OUT = 4'h5;
    IO_DIR_OUT = 4'hF;
    COMPARATOR_INPUT_EN = 2'h1;
    cyc(2);
    chk(IO_DATA, 8'h0A);
    for (int i = 0; i < 4; i++) chk(PAD_IO[i][3:2], {6'h00, IO_OUT[i], i == 0});
    IO_IN = 4'hF;
    IO_DIR_OUT = 4'h0;
    COMPARATOR_INPUT_EN = 2'h0;
    strap_low = 1'b1;
    cyc(2);
    chk(DBG_RX_BIT, 8'h00);
    strap_low = 1'b0;
    cyc(2);
    chk(DBG_RX_BIT, 8'h01);
    wr_opt(1'b0, 1'b0);
    chk({DBG_RX_BIT, DEBUG_LINE_IN}, 8'h02);
    wr_opt(1'b0, 1'b1);
    $display("t_paths done");
  endtask : t_paths

  task automatic t_busclk();
    logic prev;
    @(posedge INTERNAL_CLOCK_SOURCE);
    #1;
    prev = BUS_CLK;
    for (int i = 0; i < 4; i++) begin
      @(posedge INTERNAL_CLOCK_SOURCE);
      #1;
      chk(BUS_CLK, {7'h00, ~prev});
      prev = BUS_CLK;
    end
    cyc(1);
    $display("t_busclk done");
  endtask : t_busclk

  initial begin
    do_reset(1'b1, 1'b0);
    t_por();
    t_strap();
    t_bit();
    t_gpout();
    t_kbd();
    t_rst_pin();
    t_paths();
    t_busclk();
    tally_and_finish();
  end
endmodule : tb
